// ===== logic/lesa_pkg.sv
`default_nettype none
package lesa_pkg;

  // Operation codes presented by the instruction decoder
  localparam logic [3:0] OP_LOAD  = 4'h0;  // Load immediate, test access
  localparam logic [3:0] OP_AND   = 4'h1;
  localparam logic [3:0] OP_OR    = 4'h2;
  localparam logic [3:0] OP_XOR   = 4'h3;
  localparam logic [3:0] OP_NOT   = 4'h4;
  localparam logic [3:0] OP_ZEXT  = 4'h5;  // zero_extend_op
  localparam logic [3:0] OP_SEXT  = 4'h6;  // sign_extend_op
  localparam logic [3:0] OP_ASHL  = 4'h7;  // arith_shift_left_op
  localparam logic [3:0] OP_ASHR  = 4'h8;  // arith_shift_right_op
  localparam logic [3:0] OP_TSET  = 4'h9;  // test_and_set_op

  // Operand size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  // Bit forced to one by test-and-set
  localparam logic [7:0] TSET_MASK = 8'h80;

  // Register file shape
  localparam int REG_COUNT  = 8;
  localparam int DATA_WIDTH = 32;

  // Reset values
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

  // Sequencer states
  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_EXEC,
    ST_MEM_READ,
    ST_MEM_WRITE
  } lesa_state_t;

endpackage
`default_nettype wire

// ===== logic/lesa_reg_file.sv
`timescale 1ns/10ps
`default_nettype none
module lesa_reg_file
#(
  parameter int DEPTH = lesa_pkg::REG_COUNT,
  parameter int WIDTH = lesa_pkg::DATA_WIDTH
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddrA,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddrB,
  output logic      [WIDTH-1:0]         rdDataA,
  output logic      [WIDTH-1:0]         rdDataB,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH/8-1:0]       wrByteEn,
  input  wire logic [WIDTH-1:0]         wrData
);

  // Byte lanes need a whole number of bytes
  if ((WIDTH % 8) != 0 || DEPTH < 2)
  begin : g_bad_shape
    $error("lesa_reg_file: WIDTH must be bytes, DEPTH at least 2");
  end

  // Whole state: storage plus the two registered read ports
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;   // Register storage
    logic [WIDTH-1:0]            rdA;   // Read port A data
    logic [WIDTH-1:0]            rdB;   // Read port B data
  } lesa_rf_t;

  lesa_rf_t rf;       // Current state
  lesa_rf_t next_rf;  // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Read old contents, merge written bytes lane by lane
  always_comb
  begin
    next_rf     = rf;
    next_rf.rdA = rf.mem[rdAddrA];
    next_rf.rdB = rf.mem[rdAddrB];
    // Only enabled lanes change, the rest of the register is kept
    for (int i = 0; i < WIDTH / 8; i++)
    begin
      if (wrEn && wrByteEn[i])
      begin
        next_rf.mem[wrAddr][i*8 +: 8] = wrData[i*8 +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage clears at reset so reads are never undefined
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rf <= '0;
    end
    else
    begin
      rf <= next_rf;
    end
  end

  assign rdDataA = rf.rdA;
  assign rdDataB = rf.rdB;

endmodule
`default_nettype wire

// ===== logic/lesa_alu.sv
// Behaviour
// - Zero extend fills upper half with zeros
// - Sign extend copies low half sign upward
// - Test-and-set reads byte, tests, sets bit seven
// - AND destination with register or immediate
// - OR destination with register or immediate
// - XOR destination with register or immediate
// - Complement inverts destination bits
// - Arithmetic shifts move one or two places
// - Registers reachable as bytes, words, longwords
`timescale 1ns/10ps
`default_nettype none
module lesa_alu
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        opValid,
  output logic             opReady,
  input  wire logic [3:0]  opCode,
  input  wire logic [1:0]  opSize,
  input  wire logic [3:0]  opDst,
  input  wire logic [3:0]  opSrc,
  input  wire logic        opUseImm,
  input  wire logic [31:0] opImm,
  input  wire logic        opShiftTwo,
  output logic             opDone,
  output logic             opError,
  output logic [31:0]      resultData,
  output logic             condFlagN,
  output logic             condFlagZ,
  output logic             memReq,
  output logic             memWrite,
  output logic [31:0]      memAddr,
  output logic [7:0]       memWdata,
  input  wire logic        memAck,
  input  wire logic [7:0]  memRdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Operand helpers shared by both operands and the checks

  // Picks a byte, word or longword field, zero widened
  function automatic logic [31:0] fieldGet(input logic [31:0] v,
                                           input logic [1:0]  sz,
                                           input logic [3:0]  sel);
    if (sz == lesa_pkg::SIZE_BYTE)
      fieldGet = sel[3] ? {24'h0, v[7:0]} : {24'h0, v[15:8]};
    else if (sz == lesa_pkg::SIZE_WORD)
      fieldGet = sel[3] ? {16'h0, v[31:16]} : {16'h0, v[15:0]};
    else
      fieldGet = v;
  endfunction

  // Clears bits above the operand width
  function automatic logic [31:0] sizeMask(input logic [31:0] v,
                                           input logic [1:0]  sz);
    if (sz == lesa_pkg::SIZE_BYTE)
      sizeMask = {24'h0, v[7:0]};
    else if (sz == lesa_pkg::SIZE_WORD)
      sizeMask = {16'h0, v[15:0]};
    else
      sizeMask = v;
  endfunction

  // Sign bit at the operand width
  function automatic logic signBit(input logic [31:0] v,
                                   input logic [1:0]  sz);
    if (sz == lesa_pkg::SIZE_BYTE)
      signBit = v[7];
    else if (sz == lesa_pkg::SIZE_WORD)
      signBit = v[15];
    else
      signBit = v[31];
  endfunction

  // One place right, sign copied into the vacated top bit
  function automatic logic [31:0] sarOnce(input logic [31:0] v,
                                          input logic [1:0]  sz);
    if (sz == lesa_pkg::SIZE_BYTE)
      sarOnce = {24'h0, v[7], v[7:1]};
    else if (sz == lesa_pkg::SIZE_WORD)
      sarOnce = {16'h0, v[15], v[15:1]};
    else
      sarOnce = {v[31], v[31:1]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    lesa_pkg::lesa_state_t state;    // Sequencer
    logic [3:0]            op;       // Captured operation
    logic [1:0]            size;     // Captured operand size
    logic [3:0]            dst;      // Destination field select
    logic [3:0]            src;      // source_register field select
    logic                  useImm;   // Second operand is immediate
    logic [31:0]           imm;      // Immediate data
    logic                  two;      // Shift by two places
    logic [31:0]           opA;      // Destination operand used
    logic [31:0]           opB;      // Second operand used
    logic [31:0]           result;   // Last result at operand width
    logic                  flagN;    // condition_code_register N
    logic                  flagZ;    // condition_code_register Z
    logic                  done;     // Completion pulse
    logic                  err;      // Refused operation pulse
    logic                  memReq;   // Memory request level
    logic                  memWrite; // Request is the write-back
    logic [31:0]           memAddr;  // Pointer register value
    logic [7:0]            memWdata; // Byte written back
  } lesa_core_t;

  lesa_core_t st;       // Current state
  lesa_core_t next_st;  // Next state

  logic [31:0] rdDst;     // Destination register, registered read
  logic [31:0] rdSrc;     // Source register, registered read
  logic [31:0] aVal;      // Destination field
  logic [31:0] bVal;      // Second operand field
  logic [31:0] resVal;    // Result at operand width
  logic        illegal;   // Size not allowed for the operation
  logic        wrEn;      // Register file write
  logic [3:0]  wrByteEn;  // Register file byte lanes
  logic [31:0] wrData;    // Register file data, lane replicated

  ////////////////////////////////////////////////////////////////////////////
  // General registers; reads follow the decoder fields every cycle
  lesa_reg_file
  #(
    .DEPTH (lesa_pkg::REG_COUNT),
    .WIDTH (lesa_pkg::DATA_WIDTH)
  )
  u_regs
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .rdAddrA  (opDst[2:0]),
    .rdAddrB  (opSrc[2:0]),
    .rdDataA  (rdDst),
    .rdDataB  (rdSrc),
    .wrEn     (wrEn),
    .wrAddr   (st.dst[2:0]),
    .wrByteEn (wrByteEn),
    .wrData   (wrData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Datapath and sequencer
  always_comb
  begin
    next_st  = st;
    next_st.done = 1'b0;
    next_st.err  = 1'b0;
    aVal     = fieldGet(rdDst, st.size, st.dst);
    bVal     = st.useImm ? sizeMask(st.imm, st.size)
                         : fieldGet(rdSrc, st.size, st.src);
    resVal   = aVal;
    wrEn     = 1'b0;
    // Lane choice follows the byte/word/longword register naming
    if (st.size == lesa_pkg::SIZE_BYTE)
      wrByteEn = st.dst[3] ? 4'h1 : 4'h2;
    else if (st.size == lesa_pkg::SIZE_WORD)
      wrByteEn = st.dst[3] ? 4'hC : 4'h3;
    else
      wrByteEn = 4'hF;
    // Extends make no sense on bytes; shifts and logic take any size
    illegal  = ((st.op == lesa_pkg::OP_ZEXT) || (st.op == lesa_pkg::OP_SEXT))
               && (st.size == lesa_pkg::SIZE_BYTE);
    case (st.op)
      lesa_pkg::OP_LOAD: resVal = bVal;
      lesa_pkg::OP_AND:  resVal = aVal & bVal;
      lesa_pkg::OP_OR:   resVal = aVal | bVal;
      lesa_pkg::OP_XOR:  resVal = aVal ^ bVal;
      lesa_pkg::OP_NOT:  resVal = ~aVal;
      lesa_pkg::OP_ZEXT:
        resVal = (st.size == lesa_pkg::SIZE_WORD) ? {24'h0, aVal[7:0]}
                                                  : {16'h0, aVal[15:0]};
      lesa_pkg::OP_SEXT:
        resVal = (st.size == lesa_pkg::SIZE_WORD)
                 ? {16'h0, {8{aVal[7]}}, aVal[7:0]}
                 : {{16{aVal[15]}}, aVal[15:0]};
      lesa_pkg::OP_ASHL:
        resVal = st.two ? {aVal[29:0], 2'b00} : {aVal[30:0], 1'b0};
      lesa_pkg::OP_ASHR:
        resVal = st.two ? sarOnce(sarOnce(aVal, st.size), st.size)
                        : sarOnce(aVal, st.size);
      default: resVal = aVal;
    endcase
    resVal = sizeMask(resVal, st.size);
    wrData = (st.size == lesa_pkg::SIZE_BYTE) ? {4{resVal[7:0]}}
           : (st.size == lesa_pkg::SIZE_WORD) ? {2{resVal[15:0]}}
           : resVal;
    case (st.state)
      // Take a new operation; register reads land next cycle
      lesa_pkg::ST_IDLE:
      begin
        if (opValid)
        begin
          next_st.op     = opCode;
          next_st.size   = (opCode == lesa_pkg::OP_TSET) ? lesa_pkg::SIZE_LONG
                                                        : opSize;
          next_st.dst    = opDst;
          next_st.src    = opSrc;
          next_st.useImm = opUseImm;
          next_st.imm    = opImm;
          next_st.two    = opShiftTwo;
          next_st.state  = lesa_pkg::ST_EXEC;
        end
      end
      // Compute and write back, or start the memory read
      lesa_pkg::ST_EXEC:
      begin
        next_st.opA = aVal;
        next_st.opB = bVal;
        if (st.op == lesa_pkg::OP_TSET)
        begin
          // Pointer index is trusted to be 0, 1, 4 or 5
          next_st.memAddr  = rdDst;
          next_st.memReq   = 1'b1;
          next_st.memWrite = 1'b0;
          next_st.state    = lesa_pkg::ST_MEM_READ;
        end
        else if (illegal)
        begin
          next_st.err   = 1'b1;
          next_st.done  = 1'b1;
          next_st.state = lesa_pkg::ST_IDLE;
        end
        else
        begin
          wrEn           = 1'b1;
          next_st.result = resVal;
          if (st.op != lesa_pkg::OP_LOAD)
          begin
            next_st.flagN = signBit(resVal, st.size);
            next_st.flagZ = (resVal == 32'h0000_0000);
          end
          next_st.done  = 1'b1;
          next_st.state = lesa_pkg::ST_IDLE;
        end
      end
      // Flags come from the byte as read, before bit seven is set
      lesa_pkg::ST_MEM_READ:
      begin
        if (memAck)
        begin
          next_st.result   = {24'h0, memRdata};
          next_st.flagN    = memRdata[7];
          next_st.flagZ    = (memRdata == 8'h00);
          next_st.memWdata = memRdata | lesa_pkg::TSET_MASK;
          next_st.memWrite = 1'b1;
          next_st.state    = lesa_pkg::ST_MEM_WRITE;
        end
      end
      // Request held until the write-back is acknowledged
      lesa_pkg::ST_MEM_WRITE:
      begin
        if (memAck)
        begin
          next_st.memReq   = 1'b0;
          next_st.memWrite = 1'b0;
          next_st.done     = 1'b1;
          next_st.state    = lesa_pkg::ST_IDLE;
        end
      end
      default: next_st.state = lesa_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st        <= '0;
      st.result <= lesa_pkg::RESULT_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign opReady    = (st.state == lesa_pkg::ST_IDLE);
  assign opDone     = st.done;
  assign opError    = st.err;
  assign resultData = st.result;
  assign condFlagN  = st.flagN;
  assign condFlagZ  = st.flagZ;
  assign memReq     = st.memReq;
  assign memWrite   = st.memWrite;
  assign memAddr    = st.memAddr;
  assign memWdata   = st.memWdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seqReadAck;
    memReq && !memWrite && memAck;
  endsequence

  sequence seqWriteBack;
    memReq && memWrite && (memWdata == ($past(memRdata) | 8'h80));
  endsequence

  chk_tset_bit: assert property (seqReadAck |=> seqWriteBack)
    else $error("write-back byte lacks bit seven");
  chk_tset_pointer: assert property (
    (st.state == lesa_pkg::ST_EXEC && st.op == lesa_pkg::OP_TSET)
    |=> memReq && !memWrite && memAddr == $past(rdDst))
    else $error("test-and-set address wrong");
  chk_zext_upper: assert property (
    opDone && !opError && st.op == lesa_pkg::OP_ZEXT
    |-> resultData[31:8] == 24'h0 || (st.size == lesa_pkg::SIZE_LONG
        && resultData[31:16] == 16'h0))
    else $error("zero extend left upper bits");
  chk_sext_copy: assert property (
    opDone && !opError && st.op == lesa_pkg::OP_SEXT
    && st.size == lesa_pkg::SIZE_WORD
    |-> resultData[15:8] == {8{st.opA[7]}})
    else $error("sign extend wrong");
  chk_and_value: assert property (
    opDone && st.op == lesa_pkg::OP_AND |-> resultData == (st.opA & st.opB))
    else $error("AND result wrong");
  chk_or_value: assert property (
    opDone && st.op == lesa_pkg::OP_OR |-> resultData == (st.opA | st.opB))
    else $error("OR result wrong");
  chk_xor_value: assert property (
    opDone && st.op == lesa_pkg::OP_XOR |-> resultData == (st.opA ^ st.opB))
    else $error("XOR result wrong");
  chk_not_value: assert property (
    opDone && st.op == lesa_pkg::OP_NOT
    |-> resultData == sizeMask(~st.opA, st.size))
    else $error("complement wrong");
  chk_ashr_sign: assert property (
    opDone && st.op == lesa_pkg::OP_ASHR && !st.two
    |-> resultData == sarOnce(st.opA, st.size))
    else $error("right shift lost sign");
  chk_ashl_two: assert property (
    opDone && st.op == lesa_pkg::OP_ASHL && st.two
    |-> resultData == sizeMask({st.opA[29:0], 2'b00}, st.size))
    else $error("left shift by two wrong");
  chk_flag_zero: assert property (
    opDone && !opError && st.op != lesa_pkg::OP_LOAD
    |-> condFlagZ == (resultData == 32'h0) &&
        // Test-and-set runs at long size but its sign is the byte's top bit
        condFlagN == ((st.op == lesa_pkg::OP_TSET) ? resultData[7]
                      : signBit(resultData, st.size)))
    else $error("flags disagree with result");
  chk_byte_lane: assert property (
    wrEn && st.size == lesa_pkg::SIZE_BYTE |-> $onehot(wrByteEn[1:0])
    && wrByteEn[3:2] == 2'b00)
    else $error("byte write touched wrong lanes");

endmodule
`default_nettype wire

// ===== test/lesa_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module lesa_mem_model
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [31:0] memAddr,
  input  wire logic [7:0]  memWdata,
  input  wire logic [1:0]  ackDelay,
  output var  logic        memAck,
  output var  logic [7:0]  memRdata
);
  logic [7:0] mem [16];   // Byte store, low address bits only
  logic       readDone;   // Read phase already answered
  logic       writeDone;  // Write phase already answered
  logic [1:0] waitCnt;    // Cycles waited in this phase

  ////////////////////////////////////////////////////////////////////////////
  // One acknowledge per phase after a chosen wait; data line churns when idle
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      memAck    <= 1'b0;
      memRdata  <= 8'h00;
      readDone  <= 1'b0;
      writeDone <= 1'b0;
      waitCnt   <= 2'h0;
    end
    else
    begin
      memAck   <= 1'b0;
      // Stale data must not look valid outside an acknowledge
      memRdata <= ~memRdata;
      if (!memReq)
      begin
        readDone  <= 1'b0;
        writeDone <= 1'b0;
        waitCnt   <= 2'h0;
      end
      else if (!memAck && (memWrite ? !writeDone : !readDone))
      begin
        if (waitCnt >= ackDelay)
        begin
          memAck  <= 1'b1;
          waitCnt <= 2'h0;
          if (memWrite)
          begin
            mem[memAddr[3:0]] <= memWdata;
            writeDone         <= 1'b1;
          end
          else
          begin
            memRdata <= mem[memAddr[3:0]];
            readDone <= 1'b1;
          end
        end
        else
          waitCnt <= waitCnt + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, ex, gt) \
  begin \
    num_checks++; \
    if ((gt) !== (ex)) \
    begin \
      errors++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module testbench;
  logic        sys_clk    = 1'b0;   // 25 MHz
  logic        rst        = 1'b1;
  logic        opValid    = 1'b0;
  logic [3:0]  opCode     = 4'h0;
  logic [1:0]  opSize     = 2'h0;
  logic [3:0]  opDst      = 4'h0;
  logic [3:0]  opSrc      = 4'h0;
  logic        opUseImm   = 1'b0;
  logic [31:0] opImm      = 32'h0;
  logic        opShiftTwo = 1'b0;
  logic [1:0]  ackDelay   = 2'h0;   // Memory answer speed
  logic        opReady, opDone, opError, condFlagN, condFlagZ;
  logic        memReq, memWrite, memAck;
  logic [31:0] resultData, memAddr;
  logic [7:0]  memWdata, memRdata;
  logic [31:0] regs [8];            // Register file model
  logic [31:0] lastRes    = 32'h0;  // Result kept across errors
  logic        lastN      = 1'b0;
  logic        lastZ      = 1'b0;
  int          errors     = 0;
  int          num_checks = 0;
  logic [3:0]  ptrIdx [4] = '{4'h0, 4'h1, 4'h4, 4'h5};

  always #20 sys_clk = ~sys_clk;

  lesa_alu u_lesa_alu (.sys_clk(sys_clk), .rst(rst), .opValid(opValid),
    .opReady(opReady), .opCode(opCode), .opSize(opSize), .opDst(opDst),
    .opSrc(opSrc), .opUseImm(opUseImm), .opImm(opImm),
    .opShiftTwo(opShiftTwo), .opDone(opDone), .opError(opError),
    .resultData(resultData), .condFlagN(condFlagN), .condFlagZ(condFlagZ),
    .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));
  lesa_mem_model u_lesa_mem_model (.sys_clk(sys_clk), .rst(rst),
    .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWdata(memWdata), .ackDelay(ackDelay), .memAck(memAck),
    .memRdata(memRdata));

  ////////////////////////////////////////////////////////////////////////////
  // Operand width helpers
  function automatic int wbits(input logic [1:0] sz);
    return (sz == lesa_pkg::SIZE_BYTE) ? 8 :
           (sz == lesa_pkg::SIZE_WORD) ? 16 : 32;
  endfunction
  function automatic logic [31:0] wmask(input int w);
    return (w == 32) ? 32'hFFFF_FFFF : (32'h1 << w) - 32'h1;
  endfunction

  // Register slice as selected; byte 0-7 high, word 8-15 upper
  function automatic logic [31:0] getOp(input logic [1:0] sz,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = regs[sel[2:0]];
    if (sz == lesa_pkg::SIZE_BYTE)
      return sel[3] ? {24'h0, r[7:0]} : {24'h0, r[15:8]};
    if (sz == lesa_pkg::SIZE_WORD)
      return sel[3] ? {16'h0, r[31:16]} : {16'h0, r[15:0]};
    return r;
  endfunction
  // Writes touch only the selected slice
  task automatic putOp(input logic [1:0] sz, input logic [3:0] sel,
                       input logic [31:0] v);
    if (sz == lesa_pkg::SIZE_BYTE && sel[3])
      regs[sel[2:0]][7:0] = v[7:0];
    else if (sz == lesa_pkg::SIZE_BYTE)
      regs[sel[2:0]][15:8] = v[7:0];
    else if (sz == lesa_pkg::SIZE_WORD && sel[3])
      regs[sel[2:0]][31:16] = v[15:0];
    else if (sz == lesa_pkg::SIZE_WORD)
      regs[sel[2:0]][15:0] = v[15:0];
    else
      regs[sel[2:0]] = v;
  endtask

  // Expected result at width
  function automatic logic [31:0] calc(input logic [3:0] c, input int w,
    input logic [31:0] d, input logic [31:0] s, input logic two);
    logic [31:0] r;
    case (c)
      lesa_pkg::OP_AND:  r = d & s;
      lesa_pkg::OP_OR:   r = d | s;
      lesa_pkg::OP_XOR:  r = d ^ s;
      lesa_pkg::OP_NOT:  r = ~d;
      lesa_pkg::OP_ZEXT: r = d & ((w == 32) ? 32'hFFFF : 32'hFF);
      lesa_pkg::OP_SEXT: r = (w == 32) ? {{16{d[15]}}, d[15:0]} :
                                         {{24{d[7]}}, d[7:0]};
      lesa_pkg::OP_ASHL: r = d << (two ? 2 : 1);
      lesa_pkg::OP_ASHR:
      begin
        r = d;
        repeat (two ? 2 : 1) r = (r >> 1) | ({31'h0, r[w-1]} << (w - 1));
      end
      default: r = s;
    endcase
    return r & wmask(w);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Offer one operation, wait for completion, compare done, result, flags and error, plus the memory byte for test-and-set
  task automatic do_op(input logic [3:0] c, input logic [1:0] sz,
    input logic [3:0] dst, input logic [3:0] src, input logic imm,
    input logic [31:0] iv, input logic two);
    logic [31:0] ex;
    logic        err;
    logic [3:0]  a;
    int          w;
    int          n;
    w   = (c == lesa_pkg::OP_TSET) ? 8 : wbits(sz);
    a   = regs[dst[2:0]][3:0];
    ex  = calc(c, w, getOp(sz, dst), imm ? iv & wmask(w) : getOp(sz, src), two);
    if (c == lesa_pkg::OP_TSET)
      ex = {24'h0, u_lesa_mem_model.mem[a]};
    err = (c == lesa_pkg::OP_ZEXT || c == lesa_pkg::OP_SEXT) &&
          sz == lesa_pkg::SIZE_BYTE;
    @(posedge sys_clk);
    opValid    <= 1'b1;
    opCode     <= c;
    opSize     <= sz;
    opDst      <= dst;
    opSrc      <= src;
    opUseImm   <= imm;
    opImm      <= iv;
    opShiftTwo <= two;
    @(negedge sys_clk);
    while (opReady !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    opValid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (opDone !== 1'b1 && n < 40);
    // A refused extend keeps result, flags and register
    if (!err)
    begin
      lastRes = ex;
      if (c != lesa_pkg::OP_LOAD)
      begin
        lastN = ex[w-1];
        lastZ = (ex == 32'h0);
      end
      if (c != lesa_pkg::OP_TSET)
        putOp(sz, dst, ex);
    end
    `CHECK("done", 1'b1, opDone)
    `CHECK("result", lastRes, resultData)
    `CHECK("flagN", lastN, condFlagN)
    `CHECK("flagZ", lastZ, condFlagZ)
    `CHECK("error", err, opError)
    if (c == lesa_pkg::OP_TSET)
      `CHECK("memByte", ex[7:0] | lesa_pkg::TSET_MASK, u_lesa_mem_model.mem[a])
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [1:0] sz;
    logic [3:0] d;
    void'($urandom(48));
    for (int i = 0; i < 8; i++) regs[i] = 32'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHECK("readyReset", 1'b1, opReady)
    `CHECK("resultReset", 32'h0, resultData)
    $display("test reset done");
    for (int i = 0; i < 8; i++)
      do_op(lesa_pkg::OP_LOAD, lesa_pkg::SIZE_LONG, i[3:0], 4'h0, 1'b1,
            $urandom(), 1'b0);
    // Sign boundaries, refused byte extend, zero result
    do_op(lesa_pkg::OP_LOAD, lesa_pkg::SIZE_LONG, 4'h0, 4'h0, 1'b1, 32'h8000_0080, 1'b0);
    do_op(lesa_pkg::OP_SEXT, lesa_pkg::SIZE_WORD, 4'h0, 4'h0, 1'b0, 32'h0, 1'b0);
    do_op(lesa_pkg::OP_SEXT, lesa_pkg::SIZE_LONG, 4'h0, 4'h0, 1'b0, 32'h0, 1'b0);
    do_op(lesa_pkg::OP_ZEXT, lesa_pkg::SIZE_BYTE, 4'h8, 4'h0, 1'b0, 32'h0, 1'b0);
    do_op(lesa_pkg::OP_ASHR, lesa_pkg::SIZE_LONG, 4'h0, 4'h0, 1'b0, 32'h0, 1'b1);
    do_op(lesa_pkg::OP_ASHL, lesa_pkg::SIZE_BYTE, 4'h8, 4'h0, 1'b0, 32'h0, 1'b1);
    do_op(lesa_pkg::OP_AND, lesa_pkg::SIZE_WORD, 4'h9, 4'h0, 1'b1, 32'h0, 1'b0);
    $display("test corners done");
    repeat (200)
    begin
      sz = 2'($urandom_range(2, 0));
      d  = 4'($urandom_range(15, 0));
      if (sz == lesa_pkg::SIZE_LONG)
        d[3] = 1'b0;
      do_op(4'($urandom_range(8, 1)), sz, d, 4'($urandom_range(15, 0)) &
            ((sz == lesa_pkg::SIZE_LONG) ? 4'h7 : 4'hF), 1'($urandom()),
            $urandom(), 1'($urandom()));
    end
    $display("test random done");
    for (int k = 0; k < 12; k++)
    begin
      d        = ptrIdx[k % 4];
      ackDelay = 2'($urandom_range(3, 0));
      do_op(lesa_pkg::OP_LOAD, lesa_pkg::SIZE_LONG, d, 4'h0, 1'b1,
            32'($urandom_range(15, 0)), 1'b0);
      u_lesa_mem_model.mem[regs[d[2:0]][3:0]] = (k == 0) ? 8'h00 :
        (k == 1) ? 8'hC3 : 8'($urandom());
      do_op(lesa_pkg::OP_TSET, 2'h0, d, 4'h0, 1'b0, 32'h0, 1'b0);
    end
    $display("test test_and_set done");
    give_verdict();
  end

  // Cut a hang short well beyond the expected run
  initial
  begin
    #(40 * 20000);
    errors++;
    $display("test watchdog expired");
    give_verdict();
  end
endmodule
`default_nettype wire
